//--- inc/scd_pkg.sv
// shared constants and types for the system_clock_three and oscillator dividers
package scd_pkg;

  // ---------------------------------------------------------------
  // apb geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 16; // apb address width
  localparam int unsigned DATA_W = 32; // apb data width
  localparam int unsigned REG_W = 16; // width of each control register
  localparam logic [ADDR_W-1:0] WORD_SCALE = 16'h0004; // bytes per word

  // ---------------------------------------------------------------
  // register indexes (printed offsets) and their byte addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SYSTEM_CLOCK_THREE_DIV_IDX = 16'h1c90;
  localparam logic [ADDR_W-1:0] OSC_OUT3_DIV_IDX = 16'h1c92;
  localparam logic [ADDR_W-1:0] THIRD_CLOCK_OUTPUT_PIN_SEL_IDX = 16'h1c82;
  localparam logic [ADDR_W-1:0] SYSTEM_CLOCK_THREE_DIV_ADDR =
    ADDR_W'(SYSTEM_CLOCK_THREE_DIV_IDX * WORD_SCALE);
  localparam logic [ADDR_W-1:0] OSC_OUT3_DIV_ADDR =
    ADDR_W'(OSC_OUT3_DIV_IDX * WORD_SCALE);
  localparam logic [ADDR_W-1:0] THIRD_CLOCK_OUTPUT_PIN_SEL_ADDR =
    ADDR_W'(THIRD_CLOCK_OUTPUT_PIN_SEL_IDX * WORD_SCALE);

  // ---------------------------------------------------------------
  // field layout of the divider registers
  // ---------------------------------------------------------------
  localparam int unsigned EN_BIT = 15; // divider enable
  localparam int unsigned RATIO_W = 5; // ratio field, bits 4:0
  localparam int unsigned SEL_W = 4; // third_clock_output_pin source selector, bits 3:0

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic SYSTEM_CLOCK_THREE_EN_RST = 1'h1;
  localparam logic [RATIO_W-1:0] SYSTEM_CLOCK_THREE_RATIO_RST = 5'h03;
  localparam logic OSC_EN_RST = 1'h0;
  localparam logic [RATIO_W-1:0] OSC_RATIO_RST = 5'h00;
  localparam logic [SEL_W-1:0] THIRD_CLOCK_OUTPUT_PIN_SEL_RST = 4'hb;

  // ---------------------------------------------------------------
  // system_clock_three ratio codes that are defined, and the top code of the
  // selector range that routes the oscillator divider to the pin
  // ---------------------------------------------------------------
  localparam logic [RATIO_W-1:0] SC3_DIV1 = 5'h00;
  localparam logic [RATIO_W-1:0] SC3_DIV2 = 5'h01;
  localparam logic [RATIO_W-1:0] SC3_DIV4 = 5'h03;
  localparam logic [SEL_W-1:0] SEL_OSC_MAX = 4'h7;

  // ---------------------------------------------------------------
  // carrier for one divider's control
  // ---------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic [RATIO_W-1:0] ratio;
  } scd_div_ctrl_t;

  // divider output pair: level clock and one-cycle period tick
  typedef struct packed {
    logic level;
    logic tick;
  } scd_div_out_t;

endpackage

//--- hdl/scd_clk_div.sv
// one programmable divider that counts source enable ticks
`timescale 1ns/1ns
module scd_clk_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_tick,
  input wire scd_pkg::scd_div_ctrl_t ctrl,
  output scd_pkg::scd_div_out_t div_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [scd_pkg::RATIO_W-1:0] cnt; // ticks seen in this period
  logic [scd_pkg::RATIO_W-1:0] cur; // ratio in force this period
  logic running; // enable in force this period
  logic level; // output clock level
  logic tick; // one-cycle pulse per output period
  logic [scd_pkg::RATIO_W-1:0] next_cnt;
  logic [scd_pkg::RATIO_W-1:0] next_cur;
  logic next_running;
  logic next_level;
  logic next_tick;

  // high phase length: first half of the period, rounded up
  function automatic logic [scd_pkg::RATIO_W:0] high_len(
    input logic [scd_pkg::RATIO_W-1:0] r
  );
    high_len = (({1'b0, r} + 6'h01) + 6'h01) >> 1;
  endfunction

  // ---------------------------------------------------------------
  // next state: ratio and enable are taken at a period boundary, or at once while idle
  // so a change while running never cuts a short pulse on the output
  // ---------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    next_cur = cur;
    next_running = running;
    next_level = level;
    next_tick = 1'b0;
    if (!running) begin
      // idle: output held low, pick up a new enable at once
      next_level = 1'b0;
      next_cnt = '0;
      next_cur = ctrl.ratio;
      next_running = ctrl.enable;
    end else if (src_tick) begin
      if (cnt == cur) begin
        // period ends: resample the control here, the only place while running
        next_cnt = '0;
        next_cur = ctrl.ratio;
        next_running = ctrl.enable;
        next_tick = 1'b1;
        next_level = ctrl.enable;
      end else begin
        next_cnt = cnt + 5'h01;
        next_level = ({1'b0, cnt} + 6'h01) < high_len(cur);
      end
    end else if (cur == '0) begin
      // divide by one follows the source ticks themselves
      next_level = 1'b0;
    end
  end

  // register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      cur <= '0;
      running <= 1'b0;
      level <= 1'b0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      cur <= next_cur;
      running <= next_running;
      level <= next_level;
      tick <= next_tick;
    end
  end

  // outputs straight from flip-flops
  assign div_out.level = level;
  assign div_out.tick = tick;

endmodule

//--- hdl/scd_top.sv
// apb control registers and the system_clock_three and oscillator dividers
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
module scd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_tick,
  input wire logic bypass_tick,
  input wire logic pll_tick,
  input wire logic pll_select,
  output logic system_clock_three,
  output logic system_clock_three_tick,
  output logic osc_div_tick,
  output logic third_clock_output_pin
);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  scd_pkg::scd_div_ctrl_t system_clock_three_divider_ctrl; // system_clock_three divider
  scd_pkg::scd_div_ctrl_t osc_out3_divider_ctrl; // oscillator divider
  logic [scd_pkg::SEL_W-1:0] third_clock_output_source_select;
  scd_pkg::scd_div_ctrl_t next_system_clock_three_divider_ctrl;
  scd_pkg::scd_div_ctrl_t next_osc_out3_divider_ctrl;
  logic [scd_pkg::SEL_W-1:0] next_third_clock_output_source_select;

  // ---------------------------------------------------------------
  // bus side signals
  // ---------------------------------------------------------------
  logic [31:0] next_prdata; // read data captured in the setup cycle
  logic setup_phase; // first cycle of a transfer
  logic access_phase; // second cycle, the one that completes
  logic hit_sc3; // address decodes to the system_clock_three divider
  logic hit_osc; // address decodes to the oscillator divider
  logic hit_sel; // address decodes to the third_clock_output_pin selector
  logic mapped; // any register hit
  logic wr_lo; // byte lane 0 written
  logic wr_hi; // byte lane 1 written
  logic do_write; // write completes this cycle

  // ---------------------------------------------------------------
  // divider plumbing
  // ---------------------------------------------------------------
  scd_pkg::scd_div_ctrl_t sc3_eff; // decoded system_clock_three control
  scd_pkg::scd_div_out_t sc3_out; // system_clock_three divider result
  scd_pkg::scd_div_out_t osc_out; // oscillator divider result
  logic sc3_src_tick; // chosen source for the system_clock_three divider
  logic next_pin; // next level of the third_clock_output_pin pin

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // pack a divider control into its 16-bit register image; the bits
  // between the enable and the ratio are always zero
  function automatic logic [31:0] div_image(
    input scd_pkg::scd_div_ctrl_t c
  );
    div_image = '0;
    div_image[scd_pkg::EN_BIT] = c.enable;
    div_image[scd_pkg::RATIO_W-1:0] = c.ratio;
  endfunction

  // merge a write into a divider control, honouring byte strobes;
  // only bit 15 and bits 4:0 are stored, the rest is dropped
  function automatic scd_pkg::scd_div_ctrl_t div_merge(
    input scd_pkg::scd_div_ctrl_t c,
    input logic [31:0] d,
    input logic lo,
    input logic hi
  );
    div_merge = c;
    if (hi) begin
      div_merge.enable = d[scd_pkg::EN_BIT];
    end
    if (lo) begin
      div_merge.ratio = d[scd_pkg::RATIO_W-1:0];
    end
  endfunction

  // map a system_clock_three ratio code to the count used by the divider;
  // reserved codes must not be programmed, and if one is, the safe
  // divide by four is used rather than an undefined rate
  function automatic logic [scd_pkg::RATIO_W-1:0] sc3_decode(
    input logic [scd_pkg::RATIO_W-1:0] code
  );
    case (code)
      scd_pkg::SC3_DIV1: begin
        sc3_decode = scd_pkg::SC3_DIV1;
      end
      scd_pkg::SC3_DIV2: begin
        sc3_decode = scd_pkg::SC3_DIV2;
      end
      scd_pkg::SC3_DIV4: begin
        sc3_decode = scd_pkg::SC3_DIV4;
      end
      default: begin
        sc3_decode = scd_pkg::SC3_DIV4;
      end
    endcase
  endfunction

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign hit_sc3 = (paddr == scd_pkg::SYSTEM_CLOCK_THREE_DIV_ADDR);
  assign hit_osc = (paddr == scd_pkg::OSC_OUT3_DIV_ADDR);
  assign hit_sel = (paddr == scd_pkg::THIRD_CLOCK_OUTPUT_PIN_SEL_ADDR);
  assign mapped = hit_sc3 || hit_osc || hit_sel;
  assign wr_lo = pstrb[0];
  assign wr_hi = pstrb[1];
  // zero wait states: every transfer completes in its access cycle
  assign do_write = access_phase && pwrite && mapped;

  // handshake outputs are combinational on purpose
  assign pready = access_phase;
  // unmapped addresses complete with an error and change nothing
  assign pslverr = access_phase && !mapped;

  // ---------------------------------------------------------------
  // register next values
  // ---------------------------------------------------------------
  always_comb begin
    next_system_clock_three_divider_ctrl = system_clock_three_divider_ctrl;
    next_osc_out3_divider_ctrl = osc_out3_divider_ctrl;
    next_third_clock_output_source_select =
      third_clock_output_source_select;
    if (do_write && hit_sc3) begin
      // enable in bit 15, ratio in bits 4:0
      next_system_clock_three_divider_ctrl = div_merge(system_clock_three_divider_ctrl,
        pwdata, wr_lo, wr_hi);
    end
    if (do_write && hit_osc) begin
      next_osc_out3_divider_ctrl = div_merge(osc_out3_divider_ctrl,
        pwdata, wr_lo, wr_hi);
    end
    if (do_write && hit_sel && wr_lo) begin
      next_third_clock_output_source_select =
        pwdata[scd_pkg::SEL_W-1:0];
    end
  end

  // register stage with documented reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_clock_three_divider_ctrl.enable <= scd_pkg::SYSTEM_CLOCK_THREE_EN_RST;
      system_clock_three_divider_ctrl.ratio <= scd_pkg::SYSTEM_CLOCK_THREE_RATIO_RST;
      osc_out3_divider_ctrl.enable <= scd_pkg::OSC_EN_RST;
      osc_out3_divider_ctrl.ratio <= scd_pkg::OSC_RATIO_RST;
      third_clock_output_source_select <= scd_pkg::THIRD_CLOCK_OUTPUT_PIN_SEL_RST;
    end else begin
      system_clock_three_divider_ctrl <= next_system_clock_three_divider_ctrl;
      osc_out3_divider_ctrl <= next_osc_out3_divider_ctrl;
      third_clock_output_source_select <=
        next_third_clock_output_source_select;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // captured in the setup cycle so prdata is a flip-flop and stable
  // through the whole access cycle
  always_comb begin
    next_prdata = prdata;
    if (setup_phase && !pwrite) begin
      if (hit_sc3) begin
        next_prdata = div_image(system_clock_three_divider_ctrl);
      end else if (hit_osc) begin
        next_prdata = div_image(osc_out3_divider_ctrl);
      end else if (hit_sel) begin
        next_prdata = '0;
        next_prdata[scd_pkg::SEL_W-1:0] =
          third_clock_output_source_select;
      end else begin
        // unmapped: reads as zero alongside the error
        next_prdata = '0;
      end
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // system_clock_three divider
  // ---------------------------------------------------------------
  // the same divider sits after the bypass/pll choice, so it acts in
  // both paths; switching the source mid-period only stretches or
  // shortens that one period, the divider itself never glitches
  assign sc3_src_tick = pll_select ? pll_tick : bypass_tick;
  assign sc3_eff.enable = system_clock_three_divider_ctrl.enable;
  assign sc3_eff.ratio = sc3_decode(system_clock_three_divider_ctrl.ratio);

  scd_clk_div u_system_clock_three_divider (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(sc3_src_tick),
    .ctrl(sc3_eff),
    .div_out(sc3_out)
  );

  // ---------------------------------------------------------------
  // oscillator divider
  // ---------------------------------------------------------------
  // fed by the raw oscillator tick, never by the pll; the code plus
  // one is the division, so all 32 ratios are legal
  scd_clk_div u_oscillator_divider (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(osc_tick),
    .ctrl(osc_out3_divider_ctrl),
    .div_out(osc_out)
  );

  // ---------------------------------------------------------------
  // third_clock_output_pin pin select
  // ---------------------------------------------------------------
  // other selector codes pick debug points that live outside this
  // block; here they leave the pin low
  always_comb begin
    next_pin = 1'b0;
    if (third_clock_output_source_select <= scd_pkg::SEL_OSC_MAX) begin
      next_pin = osc_out.level;
    end
  end

  // pin register keeps the output free of decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      third_clock_output_pin <= 1'b0;
    end else begin
      third_clock_output_pin <= next_pin;
    end
  end

  // ---------------------------------------------------------------
  // clock outputs
  // ---------------------------------------------------------------
  assign system_clock_three = sc3_out.level;
  assign system_clock_three_tick = sc3_out.tick;
  assign osc_div_tick = osc_out.tick;

endmodule

//--- verif/scd_top_assertions.sv
// concurrent checks on the ports of the divider block
`timescale 1ns/1ns
module scd_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic osc_tick,
  input wire logic bypass_tick,
  input wire logic pll_tick,
  input wire logic pll_select,
  input wire logic system_clock_three,
  input wire logic system_clock_three_tick,
  input wire logic osc_div_tick,
  input wire logic third_clock_output_pin
);
  // ------------------------------------------------------------
  // shadow state kept from the bus traffic
  // ------------------------------------------------------------
  localparam logic [15:0] A_SC3 = scd_pkg::SYSTEM_CLOCK_THREE_DIV_ADDR;
  localparam logic [15:0] A_OSC = scd_pkg::OSC_OUT3_DIV_ADDR;
  localparam logic [15:0] A_SEL = scd_pkg::THIRD_CLOCK_OUTPUT_PIN_SEL_ADDR;
  logic rd; // read in its access cycle
  logic wr; // write taken at this edge
  logic sc3_src; // source tick the system_clock_three divider should see
  logic sc3_wr; // system_clock_three control touched since reset
  logic osc_wr; // oscillator control touched since reset
  logic osc_on; // oscillator enable ever written as one
  logic [3:0] sel_q; // shadow of the pin selector
  assign rd = psel && penable && !pwrite;
  assign wr = psel && penable && pwrite;
  assign sc3_src = pll_select ? pll_tick : bypass_tick;
  // sticky flags only ever widen, so a stale flag never fires falsely
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc3_wr <= 1'b0;
      osc_wr <= 1'b0;
      osc_on <= 1'b0;
      sel_q <= scd_pkg::THIRD_CLOCK_OUTPUT_PIN_SEL_RST;
    end else if (wr) begin
      if (paddr == A_SC3) sc3_wr <= 1'b1;
      if (paddr == A_OSC) osc_wr <= 1'b1;
      if (paddr == A_OSC && pstrb[1] && pwdata[15]) osc_on <= 1'b1;
      if (paddr == A_SEL && pstrb[0]) sel_q <= pwdata[3:0];
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rsvd_zero;
    rd && (paddr == A_SC3 || paddr == A_OSC) |->
      prdata[14:5] == 10'h000 && prdata[31:16] == 16'h0000;
  endproperty
  property p_sc3_reset;
    rd && paddr == A_SC3 && !sc3_wr |-> prdata == 32'h00008003;
  endproperty
  property p_osc_reset;
    rd && paddr == A_OSC && !osc_wr |-> prdata == 32'h00000000;
  endproperty
  property p_osc_off;
    !osc_on |-> !osc_div_tick && !third_clock_output_pin;
  endproperty
  property p_ready;
    psel && !penable ##1 psel && penable |-> pready;
  endproperty
  property p_unmapped;
    psel && penable && paddr != A_SC3 && paddr != A_OSC &&
      paddr != A_SEL |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_sc3_src;
    system_clock_three_tick |-> $past(sc3_src);
  endproperty
  property p_osc_src;
    osc_div_tick |-> $past(osc_tick);
  endproperty
  property p_pin_sel;
    $rose(third_clock_output_pin) |->
      $past(sel_q) <= 4'h7 || $past(sel_q, 2) <= 4'h7;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved divider bits read nonzero");
  a_sc3_reset: assert property (p_sc3_reset)
    else $error("system_clock_three control reset value wrong");
  a_osc_reset: assert property (p_osc_reset)
    else $error("oscillator control reset value wrong");
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator divider active while disabled");
  a_ready: assert property (p_ready)
    else $error("no ready in access cycle");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_sc3_src: assert property (p_sc3_src)
    else $error("system_clock_three tick without selected source tick");
  a_osc_src: assert property (p_osc_src)
    else $error("oscillator tick without raw oscillator tick");
  a_pin_sel: assert property (p_pin_sel)
    else $error("pin toggled under a non-oscillator selector");
  c_sc3: cover property (system_clock_three_tick);
  c_osc: cover property (osc_div_tick);
  c_pin: cover property ($rose(third_clock_output_pin));
endmodule
bind scd_top scd_top_assertions u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .osc_tick,
  .bypass_tick, .pll_tick, .pll_select, .system_clock_three, .system_clock_three_tick,
  .osc_div_tick, .third_clock_output_pin);

//--- verif/scd_top_tb.sv
// self-checking bench for the system_clock_three and oscillator dividers
`timescale 1ns/1ns
module scd_top_tb;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  localparam logic [15:0] A_SC3 = scd_pkg::SYSTEM_CLOCK_THREE_DIV_ADDR;
  localparam logic [15:0] A_OSC = scd_pkg::OSC_OUT3_DIV_ADDR;
  localparam logic [15:0] A_SEL = scd_pkg::THIRD_CLOCK_OUTPUT_PIN_SEL_ADDR;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pll_select = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [2:0] src = 3'h0; // oscillator, pll, bypass tick pulses
  logic [31:0] prdata;
  logic pready, pslverr, system_clock_three, system_clock_three_tick;
  logic osc_div_tick, third_clock_output_pin, pin_d;
  int fails = 0, compares = 0, cyc = 0;
  int n_sc3, n_osc, n_hi, n_rise; // event counts in a window
  always #50 pclk = ~pclk;
  scd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_tick(src[2]), .bypass_tick(src[0]), .pll_tick(src[1]),
    .pll_select(pll_select), .system_clock_three(system_clock_three),
    .system_clock_three_tick(system_clock_three_tick), .osc_div_tick(osc_div_tick),
    .third_clock_output_pin(third_clock_output_pin));
  // counts on the falling edge, where outputs are settled
  always @(negedge pclk) begin
    n_sc3 += (system_clock_three_tick === 1'b1);
    n_osc += (osc_div_tick === 1'b1);
    n_hi += (system_clock_three === 1'b1);
    n_rise += (third_clock_output_pin === 1'b1 && pin_d === 1'b0);
    pin_d = third_clock_output_pin;
  end
  // hang guard: the whole run needs well under this many cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done;
    end
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer; waits for ready, never assumes a latency
  task automatic apb(input logic w, input logic [15:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, logic [31:0] d, logic [3:0] s);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, s, q, e);
  endtask
  task automatic rdchk(input string n, logic [15:0] a, logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, q, e);
    chk(n, x, q);
    chk("mapped err", 32'h0, {31'h0, e});
  endtask
  // k pulses on mask m, the other sources pulse in between
  task automatic pulse(input logic [2:0] m, input int k);
    repeat (k) begin
      @(posedge pclk);
      src <= m;
      @(posedge pclk);
      src <= ~m;
    end
    @(posedge pclk);
    src <= 3'h0;
  endtask
  // flush to a period boundary, then count a clean window
  task automatic run(input logic [2:0] m, input int flush, input int k);
    pulse(m, flush);
    repeat (3) @(posedge pclk);
    n_sc3 = 0;
    n_osc = 0;
    n_hi = 0;
    n_rise = 0;
    pulse(m, k);
    repeat (3) @(posedge pclk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rdchk("sc3 reset", A_SC3, 32'h00008003);
    rdchk("osc reset", A_OSC, 32'h00000000);
    rdchk("sel reset", A_SEL, 32'h0000000b);
    run(3'h1, 0, 8);
    chk("sc3 div4 ticks", 32'd2, n_sc3);
    chk("sc3 level seen", 32'd1, {31'h0, n_hi != 0});
    chk("osc idle ticks", 32'd0, n_osc + n_rise);
  endtask
  task automatic t_fields;
    logic [31:0] q;
    logic e;
    wr(A_SC3, 32'hffffffe3, 4'hf);
    rdchk("sc3 reserved", A_SC3, 32'h00008003);
    wr(A_OSC, 32'hffff801f, 4'h1);
    rdchk("osc lane0 only", A_OSC, 32'h0000001f);
    apb(1'b0, 16'h7244, 32'h0, 4'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask
  task automatic t_sc3;
    logic [4:0] c[3] = '{5'h00, 5'h01, 5'h03};
    int old;
    old = 4;
    for (int i = 0; i < 3; i++) begin
      pll_select <= i[0];
      wr(A_SC3, {16'h0000, 11'h400, c[i]}, 4'h3);
      run(i[0] ? 3'h2 : 3'h1, old * (c[i] + 1), 8);
      chk("sc3 ticks", 32'(8 / (c[i] + 1)), n_sc3);
      old = c[i] + 1;
    end
    wr(A_SC3, 32'h00000003, 4'h3);
    run(3'h2, 4, 8);
    chk("sc3 off ticks", 32'd0, n_sc3 + n_hi);
  endtask
  // codes span divide by one to thirty-two, selector in and out of range
  task automatic t_osc;
    logic [4:0] c[5] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h1f};
    logic [3:0] s[5] = '{4'h0, 4'h7, 4'h3, 4'h8, 4'hf};
    int old;
    old = 1;
    for (int i = 0; i < 5; i++) begin
      pll_select <= i[0];
      wr(A_SEL, {28'h0, s[i]}, 4'h1);
      wr(A_OSC, {16'h0000, 11'h400, c[i]}, 4'h3);
      run(3'h4, old * (c[i] + 1), 3 * (c[i] + 1));
      chk("osc ticks", 32'd3, n_osc);
      chk("pin rises", {31'h0, s[i] <= 4'h7},
        {31'h0, n_rise != 0});
      old = c[i] + 1;
    end
  endtask
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_fields;
    t_sc3;
    t_osc;
    test_done;
  end
endmodule
